// File: core/sblp_boot_handler.sv
// sblp_boot_handler: serial boot session, mode detect to password.
// assumes flash-side inputs are steady and on clk_i; pins are not.
`timescale 1ns/1ps
module sblp_boot_handler #(
  parameter int DIV_MIN = 4,
  parameter int DIV_MAX = 4095,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic rxd_i,
  input wire logic sclk_i,
  input wire logic [sblp_pkg::PW_BITS-1:0] stored_pw_i,
  input wire logic [31:0] revision_i,
  input wire logic [15:0] flash_sum_i,
  input wire logic erase_done_i,
  output logic txd_o,
  output logic erase_req_o,
  output logic security_flag_o,
  output logic pw_error_o,
  output logic receive_enable_bit_o,
  output logic [sblp_pkg::MEAS_W-1:0] baud_divider_setting_o,
  output sblp_pkg::sblp_mode_t mode_o
);
  import sblp_pkg::*;

  typedef enum {
    S_MEAS, S_ABORT, S_ACK, S_CMD, S_PW, S_PWCHK,
    S_ERASE_SUB, S_ERASE_RUN, S_STREAM, S_TX
  } sblp_state_t;

  localparam logic [3:0] PW_LAST = 4'(PW_BYTES);

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic is_cmd(input logic [7:0] b);
    is_cmd = b == CMD_RAM || b == CMD_SUM || b == CMD_INFO
      || b == CMD_ERASE;
  endfunction : is_cmd

  function automatic logic [7:0] pw_byte(
    input logic [PW_BITS-1:0] pw, input logic [3:0] idx);
    pw_byte = pw[{idx, 3'h0} +: 8];
  endfunction : pw_byte

  // uniform stored password other than erased counts as weak
  function automatic logic pw_weak(input logic [PW_BITS-1:0] pw);
    logic w;
    w = pw[7:0] != PW_ERASED;
    for (int i = 1; i < PW_BYTES; i++) begin
      w = w & (pw[i*8 +: 8] == pw[7:0]);
    end
    pw_weak = w;
  endfunction : pw_weak

  sblp_state_t state_q, ret_q;
  logic rxd_s, sclk_s, rxd_p_q, sclk_p_q;
  logic rx_en_q, io_q, uart_q, io_seen_q, low_q;
  logic meas_ok_q, meas_bad_q;
  logic [MEAS_W-1:0] meas_q, div_q, wait_q;
  logic [3:0] mbit_q;
  logic rx_act_q, rx_push_q, ovr_q;
  logic [3:0] rx_bit_q;
  logic [MEAS_W-1:0] rx_cnt_q;
  logic [7:0] rx_sh_q;
  sblp_rx_t rx_word_q, rxb;
  logic fifo_in_ready, fifo_out_valid;
  logic tx_busy_q, txd_q;
  logic [8:0] tx_sh_q;
  logic [3:0] tx_bit_q;
  logic [MEAS_W-1:0] tx_cnt_q;
  logic [7:0] tx_data_q;
  logic [3:0] prev_hi_q, idx_q;
  logic [7:0] sum_q;
  logic pw_rxerr_q, mism_q, pw_err_q;
  logic [39:0] stream_q;
  logic [2:0] sn_q;
  logic erase_busy_q, erase_req_q, sec_q;

  // ****************************************
  // pins and edges
  // ****************************************
  sblp_sync #(.RESET_VAL(1'b1)) u_rxd_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(rxd_i),
    .level_o(rxd_s)
  );
  sblp_sync #(.RESET_VAL(1'b1)) u_sclk_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(sclk_i),
    .level_o(sclk_s)
  );
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rxd_p_q <= 1'b1;
      sclk_p_q <= 1'b1;
    end else begin
      rxd_p_q <= rxd_s;
      sclk_p_q <= sclk_s;
    end
  end
  wire rxd_fall = rxd_p_q & ~rxd_s;
  wire rxd_rise = ~rxd_p_q & rxd_s;
  wire sclk_rise = ~sclk_p_q & sclk_s;
  wire sclk_fall = sclk_p_q & ~sclk_s;

  // ****************************************
  // first byte: mode and rate
  // ****************************************
  wire in_meas = state_q == S_MEAS;
  // counter restarts on the edge itself, so it reads one short
  wire [MEAS_W-1:0] meas_len = meas_q + 1'b1;
  wire [MEAS_W-1:0] uart_div = meas_len >> UART_LOW_SHIFT;
  wire uart_div_ok = uart_div >= MEAS_W'(DIV_MIN)
    && uart_div <= MEAS_W'(DIV_MAX);
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      {io_q, uart_q, io_seen_q, low_q} <= 4'h0;
      {meas_ok_q, meas_bad_q} <= 2'h0;
      meas_q <= '0;
      div_q <= '0;
      wait_q <= '0;
      mbit_q <= '0;
    end else begin
      meas_ok_q <= 1'b0;
      meas_bad_q <= 1'b0;
      if (in_meas) begin
        meas_q <= meas_q + 1'b1;
        if (sclk_rise) begin
          io_seen_q <= 1'b1;
          meas_q <= '0;
          mbit_q <= mbit_q + 1'b1;
          if (mbit_q == DATA_LAST) begin
            io_q <= 1'b1;
            div_q <= meas_len >> IO_RATE_SHIFT;
            meas_ok_q <= 1'b1;
          end
        end else if (!io_seen_q) begin
          if (wait_q != '0) begin
            wait_q <= wait_q - 1'b1;
            if (wait_q == MEAS_W'(1)) begin
              uart_q <= 1'b1;
              meas_ok_q <= 1'b1;
            end
          end else if (rxd_fall && !low_q) begin
            low_q <= 1'b1;
            meas_q <= '0;
          end else if (rxd_rise && low_q) begin
            if (uart_div_ok) begin
              div_q <= uart_div;
              wait_q <= uart_div << TAIL_SHIFT;
            end else begin
              meas_bad_q <= 1'b1;
            end
          end
        end
      end
    end
  end

  // ****************************************
  // receiver and byte FIFO
  // ****************************************
  wire rx_uart_go = rx_en_q & uart_q & ~rx_act_q & rxd_fall;
  // capture on external rising edge; half duplex
  wire rx_io_bit = rx_en_q & io_q & sclk_rise & ~tx_busy_q;
  wire [7:0] rx_next = {rxd_s, rx_sh_q[7:1]};
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      {rx_act_q, rx_push_q, ovr_q} <= 3'h0;
      rx_bit_q <= '0;
      rx_cnt_q <= '0;
      rx_sh_q <= '0;
      rx_word_q <= '0;
    end else begin
      rx_push_q <= 1'b0;
      // full FIFO drops a byte and flags the next one in uart mode
      if (rx_push_q && !fifo_in_ready) begin
        ovr_q <= 1'b1;
      end
      if (rx_io_bit) begin
        rx_sh_q <= rx_next;
        rx_bit_q <= rx_bit_q + 1'b1;
        if (rx_bit_q == DATA_LAST) begin
          rx_bit_q <= '0;
          rx_push_q <= 1'b1;
          // no error flag in clocked mode
          rx_word_q <= '{err: 1'b0, data: rx_next};
        end
      end else if (rx_uart_go) begin
        rx_act_q <= 1'b1;
        rx_cnt_q <= div_q >> 1;
        rx_bit_q <= '0;
      end else if (rx_act_q) begin
        if (rx_cnt_q != '0) begin
          rx_cnt_q <= rx_cnt_q - 1'b1;
        end else begin
          rx_cnt_q <= div_q - 1'b1;
          rx_bit_q <= rx_bit_q + 1'b1;
          if (rx_bit_q == '0 && rxd_s) begin
            rx_act_q <= 1'b0;
          end else if (rx_bit_q == FRAME_LAST) begin
            rx_act_q <= 1'b0;
            rx_push_q <= 1'b1;
            ovr_q <= rx_push_q & ~fifo_in_ready;
            rx_word_q <= '{err: ~rxd_s | ovr_q, data: rx_sh_q};
          end else if (rx_bit_q != '0) begin
            rx_sh_q <= rx_next;
          end
        end
      end
    end
  end

  wire pop = fifo_out_valid && (state_q == S_CMD
    || state_q == S_PW || state_q == S_ERASE_SUB);
  sblp_fifo #(.W(RX_W), .D(FIFO_DEPTH)) u_rx_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(rx_push_q),
    .in_data_i(rx_word_q),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(rxb),
    .out_ready_i(pop)
  );

  // ****************************************
  // transmitter
  // ****************************************
  wire tx_load = state_q == S_TX && !tx_busy_q;
  wire tx_tick = uart_q && tx_cnt_q == '0;
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      {tx_busy_q, txd_q} <= 2'h1;
      tx_sh_q <= '1;
      tx_bit_q <= '0;
      tx_cnt_q <= '0;
    end else if (tx_load) begin
      tx_busy_q <= 1'b1;
      tx_sh_q <= {1'b1, tx_data_q};
      tx_bit_q <= '0;
      tx_cnt_q <= div_q - 1'b1;
      txd_q <= io_q ? tx_data_q[0] : 1'b0;
    end else if (tx_busy_q && uart_q) begin
      tx_cnt_q <= tx_tick ? div_q - 1'b1 : tx_cnt_q - 1'b1;
      if (tx_tick && tx_bit_q == FRAME_LAST) begin
        tx_busy_q <= 1'b0;
      end else if (tx_tick) begin
        txd_q <= tx_sh_q[0];
        tx_sh_q <= {1'b1, tx_sh_q[8:1]};
        tx_bit_q <= tx_bit_q + 1'b1;
      end
    end else if (tx_busy_q && sclk_rise) begin
      // host samples on rise, next bit after fall
      tx_sh_q <= {1'b1, tx_sh_q[8:1]};
      tx_bit_q <= tx_bit_q + 1'b1;
      if (tx_bit_q == DATA_LAST) begin
        tx_busy_q <= 1'b0;
      end
    end else if (tx_busy_q && sclk_fall) begin
      txd_q <= tx_sh_q[0];
    end else if (!tx_busy_q && io_q && sclk_fall) begin
      txd_q <= 1'b1;
    end
  end

  // ****************************************
  // command replies
  // ****************************************
  wire rx_bad = rxb.err & uart_q;
  wire [7:0] sum_chk = SUM_ZERO - flash_sum_i[15:8]
    - flash_sum_i[7:0];
  wire [7:0] info_chk = SUM_ZERO - revision_i[31:24]
    - revision_i[23:16] - revision_i[15:8] - revision_i[7:0];
  // receive error keeps previous high nibble
  wire [7:0] cmd_reply = rx_bad ? {prev_hi_q, NAK_RXERR}
    : is_cmd(rxb.data) ? rxb.data : {prev_hi_q, NAK_BADCMD};
  wire [7:0] sum_next = sum_q + rxb.data;
  wire pw_fail = mism_q | pw_weak(stored_pw_i);
  // error first, then sum, then password
  wire [7:0] pw_reply = pw_rxerr_q ? ACK_PW_RXERR
    : sum_q != SUM_ZERO ? ACK_PW_BAD
    : pw_fail ? ACK_PW_BAD : ACK_PW_OK;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= S_MEAS;
      ret_q <= S_CMD;
      {rx_en_q, pw_rxerr_q, mism_q, pw_err_q} <= 4'h0;
      {erase_busy_q, erase_req_q, sec_q} <= 3'h0;
      tx_data_q <= '0;
      prev_hi_q <= '0;
      idx_q <= '0;
      sum_q <= '0;
      stream_q <= '0;
      sn_q <= '0;
    end else begin
      erase_req_q <= 1'b0;
      unique case (state_q)
        S_MEAS: begin
          rx_en_q <= 1'b0;
          if (meas_bad_q) begin
            state_q <= S_ABORT;
          end else if (meas_ok_q) begin
            state_q <= S_ACK;
          end
        end
        // silent halt: no reply, no reception
        S_ABORT: state_q <= S_ABORT;
        S_ACK: begin
          // enable reception before the ack load
          rx_en_q <= 1'b1;
          tx_data_q <= io_q ? MODE_IO : MODE_UART;
          ret_q <= S_CMD;
          state_q <= S_TX;
        end
        S_CMD: if (pop) begin
          tx_data_q <= cmd_reply;
          ret_q <= S_CMD;
          state_q <= S_TX;
          if (!rx_bad && is_cmd(rxb.data)) begin
            prev_hi_q <= rxb.data[7:4];
            unique case (rxb.data)
              CMD_RAM: begin
                ret_q <= S_PW;
                {idx_q, sum_q} <= '0;
                {pw_rxerr_q, mism_q, pw_err_q} <= 3'h0;
              end
              // only the sum leaves the device
              CMD_SUM: begin
                ret_q <= S_STREAM;
                stream_q <= {16'h0000, sum_chk, flash_sum_i[7:0],
                  flash_sum_i[15:8]};
                sn_q <= SUM_STREAM_N;
              end
              // four revision bytes, low address first
              CMD_INFO: begin
                ret_q <= S_STREAM;
                stream_q <= {info_chk, revision_i[31:24],
                  revision_i[23:16], revision_i[15:8],
                  revision_i[7:0]};
                sn_q <= INFO_STREAM_N;
              end
              CMD_ERASE: ret_q <= S_ERASE_SUB;
            endcase
          end
        end
        S_PW: if (pop) begin
          idx_q <= idx_q + 1'b1;
          sum_q <= sum_next;
          pw_rxerr_q <= pw_rxerr_q | rx_bad;
          // byte by byte, lowest address first
          if (idx_q != PW_LAST
              && rxb.data != pw_byte(stored_pw_i, idx_q)) begin
            mism_q <= 1'b1;
            pw_err_q <= 1'b1;
          end
          // the checksum byte closes the phase
          if (idx_q == PW_LAST) begin
            state_q <= S_PWCHK;
          end
        end
        S_PWCHK: begin
          // all checks pass gives the normal ack
          tx_data_q <= pw_reply;
          pw_err_q <= pw_err_q | (pw_reply == ACK_PW_BAD && pw_fail);
          ret_q <= S_CMD;
          state_q <= S_TX;
        end
        S_ERASE_SUB: if (pop) begin
          tx_data_q <= rx_bad ? {prev_hi_q, NAK_RXERR}
            : rxb.data == SUB_ERASE ? rxb.data
            : {prev_hi_q, NAK_BADCMD};
          ret_q <= (!rx_bad && rxb.data == SUB_ERASE)
            ? S_ERASE_RUN : S_CMD;
          state_q <= S_TX;
        end
        S_ERASE_RUN: begin
          // no password check; flag set on completion
          if (!erase_busy_q) begin
            erase_busy_q <= 1'b1;
            erase_req_q <= 1'b1;
          end else if (erase_done_i) begin
            erase_busy_q <= 1'b0;
            sec_q <= 1'b1;
            tx_data_q <= ACK_ERASED;
            ret_q <= S_CMD;
            state_q <= S_TX;
          end
        end
        S_STREAM: begin
          if (sn_q == '0) begin
            state_q <= S_CMD;
          end else begin
            tx_data_q <= stream_q[7:0];
            stream_q <= stream_q >> 8;
            sn_q <= sn_q - 1'b1;
            ret_q <= S_STREAM;
            state_q <= S_TX;
          end
        end
        S_TX: if (!tx_busy_q) begin
          state_q <= ret_q;
        end
      endcase
    end
  end

  assign txd_o = txd_q;
  assign erase_req_o = erase_req_q;
  assign security_flag_o = sec_q;
  assign pw_error_o = pw_err_q;
  assign receive_enable_bit_o = rx_en_q;
  assign baud_divider_setting_o = div_q;
  assign mode_o = '{uart: uart_q, io: io_q,
    halted: state_q == S_ABORT};

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_ack_out;
    tx_load && rx_en_q ##1 tx_busy_q;
  endsequence

  a_abort_stays_quiet: assert property (
    state_q == S_ABORT |=> state_q == S_ABORT && txd_o
      && !rx_en_q && !tx_busy_q)
    else $error("halted session became active");
  a_rx_off_measure: assert property (
    state_q == S_MEAS |=> !rx_en_q || state_q == S_ACK)
    else $error("reception on while measuring");
  a_ack_echo_mode: assert property (
    state_q == S_ACK |=> s_ack_out and (tx_data_q ==
      (io_q ? MODE_IO : MODE_UART)))
    else $error("mode ack wrong or before enable");
  a_io_rate_x16: assert property (
    meas_ok_q && io_q |->
      div_q == ($past(meas_q) + 1'b1) >> IO_RATE_SHIFT)
    else $error("clocked rate not sixteen times");
  a_io_no_errack: assert property (
    pop && io_q && state_q != S_PW |=> tx_data_q[3:0] != NAK_RXERR)
    else $error("error ack in clocked mode");
  a_rxerr_nak: assert property (
    pop && state_q == S_CMD && rx_bad |=>
      tx_data_q == {$past(prev_hi_q), NAK_RXERR} && ret_q == S_CMD)
    else $error("receive error reply wrong");
  a_cmd_echo_nak: assert property (
    pop && state_q == S_CMD && !rx_bad |=> tx_data_q ==
      (is_cmd($past(rxb.data)) ? $past(rxb.data)
      : {$past(prev_hi_q), NAK_BADCMD}))
    else $error("command reply wrong");
  a_pw_mismatch: assert property (
    pop && state_q == S_PW && idx_q == '0
      && rxb.data != stored_pw_i[7:0] |=> mism_q && pw_err_q)
    else $error("password mismatch not flagged");
  a_pw_sum_bad: assert property (
    state_q == S_PWCHK && !pw_rxerr_q && sum_q != SUM_ZERO
      |=> tx_data_q == ACK_PW_BAD ##1 tx_busy_q)
    else $error("bad password sum not refused");
  a_pw_accept: assert property (
    state_q == S_PWCHK && !pw_rxerr_q && sum_q == SUM_ZERO
      && !pw_fail |=> tx_data_q == ACK_PW_OK)
    else $error("good password not accepted");
  a_erase_sets_flag: assert property (
    state_q == S_ERASE_RUN && erase_busy_q && erase_done_i
      |=> sec_q && tx_data_q == ACK_ERASED && !erase_req_o)
    else $error("erase end without security flag");
endmodule : sblp_boot_handler

// File: core/sblp_pkg.sv
// sblp_pkg: protocol bytes, framing figures and carriers of the
// serial boot handler. assumes one clock domain for every user.
package sblp_pkg;
  // ****************************************
  // protocol bytes
  // ****************************************
  localparam logic [7:0] MODE_UART = 8'h86;
  localparam logic [7:0] MODE_IO = 8'h30;
  localparam logic [7:0] CMD_RAM = 8'h10;
  localparam logic [7:0] CMD_SUM = 8'h20;
  localparam logic [7:0] CMD_INFO = 8'h30;
  localparam logic [7:0] CMD_ERASE = 8'h40;
  localparam logic [7:0] SUB_ERASE = 8'h54;
  localparam logic [7:0] ACK_ERASED = 8'h4f;
  localparam logic [7:0] ACK_PW_OK = 8'h10;
  localparam logic [7:0] ACK_PW_RXERR = 8'h18;
  localparam logic [7:0] ACK_PW_BAD = 8'h11;
  localparam logic [3:0] NAK_RXERR = 4'h8;
  localparam logic [3:0] NAK_BADCMD = 4'h1;
  localparam logic [7:0] PW_ERASED = 8'hff;
  localparam logic [7:0] SUM_ZERO = 8'h00;
  // ****************************************
  // framing and sizes
  // ****************************************
  localparam int PW_BYTES = 12;
  localparam int PW_BITS = 8 * PW_BYTES;
  localparam int MEAS_W = 16;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  // first measured byte is clocked at one sixteenth of the rate
  localparam int IO_RATE_SHIFT = 4;
  // 0x86 holds the line low for start plus bit 0
  localparam int UART_LOW_SHIFT = 1;
  // eight bit times remain after the first rising edge
  localparam int TAIL_SHIFT = 3;
  localparam logic [2:0] SUM_STREAM_N = 3'h3;
  localparam logic [2:0] INFO_STREAM_N = 3'h5;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic err;
    logic [7:0] data;
  } sblp_rx_t;
  localparam int RX_W = $bits(sblp_rx_t);
  typedef struct packed {
    logic uart;
    logic io;
    logic halted;
  } sblp_mode_t;
endpackage : sblp_pkg

// File: core/sblp_sync.sv
// sblp_sync: three-flop pin synchroniser with agreement filter.
// assumes pin_i is asynchronous to clk_i.
`timescale 1ns/1ps
module sblp_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q, s2_q, s3_q, level_q;
  // first stage is read by the second only
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
  assign level_o = level_q;
endmodule : sblp_sync

// File: core/sblp_fifo.sv
// sblp_fifo: small synchronous FIFO, valid/ready on both sides.
// assumes a power-of-two depth and one clock.
`timescale 1ns/1ps
module sblp_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  assign in_ready_o = cnt_q != (AW+1)'(D);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o = mem_q[rd_q];
  // storage carries no reset to stay a plain array
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sblp_fifo

// File: sim/sblp_host.sv
// sblp_host: host end of the boot link, uart and clocked.
// assumes 8 clk per uart bit; drives at the falling edge.
`timescale 1ns/1ps
module sblp_host (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic sclk_o
);
  initial begin
    rxd_o = 1'b1;
    sclk_o = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  task automatic send(input logic [7:0] b, input logic s);
    logic [9:0] f;
    f = {s, b, 1'b0};
    cyc(6);
    for (int i = 0; i < 10; i++) begin
      rxd_o = f[i];
      cyc(i < 9 || !s ? 8 : 2);
    end
    rxd_o = 1'b1;
  endtask : send
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (txd_i !== 1'b0 && n < 9000) begin
      cyc(1);
      n++;
    end
    ok = n < 9000;
    cyc(12);
    for (int i = 0; i < 8; i++) begin
      b[i] = txd_i;
      cyc(8);
    end
  endtask : recv
  // clocked byte, h clocks per half period
  task automatic io(input logic [7:0] t, input int h,
      output logic [7:0] r);
    for (int i = 0; i < 8; i++) begin
      sclk_o = 1'b0;
      rxd_o = t[i];
      cyc(h);
      sclk_o = 1'b1;
      cyc(h);
      r[i] = txd_i;
    end
    rxd_o = 1'b1;
  endtask : io
  task automatic pulse(input int n);
    rxd_o = 1'b0;
    cyc(n);
    rxd_o = 1'b1;
  endtask : pulse
endmodule : sblp_host

// File: sim/sblp_boot_handler_bench.sv
// sblp_boot_handler_bench: self-checking bench of the boot handler.
// assumes sblp_host on the link at 8 clocks per uart bit.
`timescale 1ns/1ps
module sblp_boot_handler_bench;
  import sblp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic done = 1'b0;
  logic rxd, sclk, txd, req, sec, pwe, rxen;
  logic [15:0] div;
  sblp_mode_t mode;
  logic [95:0] pw = 96'h0c0b0a090807060504030201;
  logic [31:0] rev = 32'h44332211;
  logic [15:0] fsum = 16'h1234;
  int errors = 0;
  int check_count = 0;
  sblp_boot_handler i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .rxd_i(rxd), .sclk_i(sclk), .stored_pw_i(pw),
    .revision_i(rev), .flash_sum_i(fsum),
    .erase_done_i(done), .txd_o(txd), .erase_req_o(req),
    .security_flag_o(sec), .pw_error_o(pwe),
    .receive_enable_bit_o(rxen), .baud_divider_setting_o(div),
    .mode_o(mode));
  sblp_host i_host (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd),
    .sclk_o(sclk));
  initial forever #50 clk_i = ~clk_i;
  // flash answers each erase request
  always @(negedge clk_i) done <= req;
  task automatic chk(input logic [19:0] s, e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic tx(input logic [7:0] b);
    i_host.send(b, 1'b1);
  endtask : tx
  task automatic rx(input logic [7:0] e);
    logic [7:0] b;
    logic ok;
    i_host.recv(b, ok);
    if (ok !== 1'b1) begin
      errors++;
      end_sim;
    end
    chk(b, e);
  endtask : rx
  // bytes expected back, first in the low byte
  task automatic seq(input logic [7:0] c, input int n,
      input logic [47:0] v);
    tx(c);
    for (int i = 0; i < n; i++) rx(v[8*i+:8]);
  endtask : seq
  task automatic rst;
    reset_i = 1'b1;
    i_host.cyc(4);
    reset_i = 1'b0;
    i_host.cyc(5);
  endtask : rst
  task automatic ram(input logic [7:0] x, c, input logic s,
      input logic [7:0] e);
    seq(CMD_RAM, 1, 48'h10);
    for (int i = 0; i < 12; i++) tx(pw[8*i+:8] ^ (i == 0 ? x : 8'h0));
    i_host.send(c, s);
    rx(e);
  endtask : ram
  task automatic t_mode;
    tx(MODE_UART);
    rx(MODE_UART);
    chk({rxen, mode}, 4'hc);
    chk(div, 16'h8);
  endtask : t_mode
  task automatic t_cmd;
    seq(8'h55, 1, 48'h01);
    seq(CMD_SUM, 4, 48'hba341220);
    seq(CMD_INFO, 6, 48'h564433221130);
    rev = 32'h01020304;
    fsum = 16'hff01;
    seq(CMD_SUM, 4, 48'h0001ff20);
    seq(CMD_INFO, 6, 48'hf60102030430);
    seq(8'h77, 1, 48'h31);
  endtask : t_cmd
  task automatic t_ram;
    ram(8'h0, 8'hb2, 1'b1, ACK_PW_OK);
    chk(pwe, 1'b0);
    ram(8'h0, 8'hb3, 1'b1, ACK_PW_BAD);
    ram(8'h1, 8'hb3, 1'b1, ACK_PW_BAD);
    chk(pwe, 1'b1);
    ram(8'h0, 8'hb2, 1'b0, ACK_PW_RXERR);
    i_host.send(CMD_SUM, 1'b0);
    rx(8'h18);
    pw = {12{8'h5a}};
    ram(8'h0, 8'hc8, 1'b1, ACK_PW_BAD);
  endtask : t_ram
  task automatic t_erase;
    chk(sec, 1'b0);
    seq(CMD_ERASE, 1, 48'h40);
    seq(SUB_ERASE, 2, 48'h4f54);
    chk(sec, 1'b1);
  endtask : t_erase
  task automatic t_io;
    logic [7:0] b;
    logic [31:0] v = 32'h0001ff20;
    rst;
    i_host.io(MODE_IO, 64, b);
    i_host.cyc(50);
    i_host.io(8'hff, 64, b);
    chk(b, MODE_IO);
    chk({mode, div}, {3'h2, 16'h8});
    // full rate from the third byte on, 800 ns link clock
    i_host.io(CMD_SUM, 4, b);
    i_host.cyc(20);
    for (int i = 0; i < 4; i++) begin
      i_host.io(8'hff, 4, b);
      chk(b, v[8*i+:8]);
    end
  endtask : t_io
  // too fast a rate halts silently
  task automatic t_halt;
    logic [7:0] b;
    logic ok;
    rst;
    i_host.pulse(4);
    i_host.recv(b, ok);
    chk({mode, ok}, 4'h2);
  endtask : t_halt
  initial begin
    rst;
    t_mode;
    t_cmd;
    t_ram;
    t_erase;
    t_io;
    t_halt;
    end_sim;
  end
endmodule : sblp_boot_handler_bench
